// File: core/eda_arith_unit.sv
// eda_arith_unit: evoke decoders, accumulator/argument pair with alu,
// carry-hold and rotate-extension bits, software reached over axi4-lite
// assumes one clock; the external word port pins are asynchronous
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module eda_arith_unit
  import eda_pkg::*;
(
  // clock and reset
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_IN,
  // axi4-lite write channels
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  // axi4-lite read channels
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  // external word port
  input  wire logic [15:0] EXT_WORD_IN,
  output logic [15:0]      EXT_WORD_OUT,
  output logic             EXT_LOAD_OUT,
  // transfer handshake and status
  output logic             DATA_READY_OUT,
  output logic             DATA_ACCEPT_OUT,
  output logic             DONE_OUT,
  output logic             COND_TRUE_OUT
);

  eda_state_type            state_ff;
  eda_state_type            nxt_state;
  logic [7:0]               cw_ff;
  logic [EDA_DW-1:0]        acc_ff;
  logic [EDA_DW-1:0]        arg_ff;
  logic [EDA_DW-1:0]        temp_ff;
  logic                     carry_ff;
  logic                     link_ff;
  logic [5:0]               cond_sel_ff;
  logic [15:0]              done_cnt_ff;
  logic [EDA_DW-1:0]        ext_meta_ff;
  logic [EDA_DW-1:0]        ext_sync_ff;
  logic [EDA_STROBES-1:0]   strobe [EDA_NUM_DEC];
  logic                     active;
  logic                     start;
  logic                     jump_word;
  logic [EDA_DW:0]          alu_sum;
  logic [EDA_DW-1:0]        bus_val;
  logic                     bus_carry;
  logic                     ld_acc;
  logic                     ld_arg;
  logic                     save;
  logic [5:0]               enc;
  logic [4:0]               op;
  logic                     op_valid;
  logic [29:0]              cond_pri;
  logic [29:0]              cond_sec;
  // axi state
  logic                     aw_got_ff;
  logic                     w_got_ff;
  logic [7:0]               awaddr_ff;
  logic [31:0]              wdata_ff;
  logic                     wr_fire;
  logic                     wr_hit;

  // external word pins pass two flops before use
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      ext_meta_ff <= '0;
      ext_sync_ff <= '0;
    end
    else
    begin
      ext_meta_ff <= EXT_WORD_IN;
      ext_sync_ff <= ext_meta_ff;
    end
  end

  // top two bits 11 mark goto/if/call/exit
  assign jump_word = (cw_ff[7:6] == EDA_JUMP_CLASS);
  assign active    = (state_ff != ST_IDLE);

  // identical decoders, told apart only by their slot strap
  generate
    for (genvar g = 0; g < EDA_NUM_DEC; g++)
    begin : g_dec
      logic match;
      assign match = ~|(cw_ff[7:5] ^ EDA_SLOT_STRAPS[3*g +: 3]);
      assign strobe[g] = (match && active && !jump_word)
                         ? (EDA_STROBES'(1) << cw_ff[4:0])
                         : '0;
    end
  endgenerate

  // operation selected by the arithmetic slots
  always_comb
  begin
    op       = cw_ff[4:0];
    op_valid = (strobe[DEC_DST_A] != '0) || (strobe[DEC_DST_B] != '0)
               || (strobe[DEC_DST_A_SAVE] != '0);
    save     = strobe[DEC_DST_A_SAVE] != '0;
  end

  // operation encoder: halve, mode, func3..func0
  always_comb
  begin
    case (op)
      5'(OP_PASS_A): enc = ENC_PASS_A;
      5'(OP_PASS_B): enc = ENC_PASS_B;
      5'(OP_INC_A):  enc = ENC_INC_A;
      5'(OP_DEC_A):  enc = ENC_DEC_A;
      5'(OP_ADD):    enc = ENC_ADD;
      5'(OP_SUB):    enc = ENC_SUB;
      5'(OP_DBL_A):  enc = ENC_DBL_A;
      5'(OP_HALF_A): enc = ENC_HALF_A;
      5'(OP_HALF_B): enc = ENC_HALF_B;
      5'(OP_NOT_A):  enc = ENC_NOT_A;
      5'(OP_NOT_B):  enc = ENC_NOT_B;
      5'(OP_OR):     enc = ENC_OR;
      5'(OP_AND):    enc = ENC_AND;
      5'(OP_XOR):    enc = ENC_XOR;
      default:       enc = ENC_PASS_A;
    endcase
  end

  // alu keyed on the operation, not the code: two pairs of printed codes collide
  always_comb
  begin
    case (op)
      5'(OP_PASS_B), 5'(OP_HALF_B): alu_sum = {1'b0, arg_ff};
      5'(OP_INC_A):  alu_sum = {1'b0, acc_ff} + 17'h1;
      5'(OP_DEC_A):  alu_sum = {1'b0, acc_ff} + 17'h0ffff;
      5'(OP_ADD):    alu_sum = {1'b0, acc_ff} + {1'b0, arg_ff};
      5'(OP_SUB):    alu_sum = {1'b0, acc_ff} + {1'b0, ~arg_ff} + 17'h1;
      5'(OP_DBL_A):  alu_sum = {acc_ff, 1'b0};
      5'(OP_NOT_A):  alu_sum = {1'b0, ~acc_ff};
      5'(OP_NOT_B):  alu_sum = {1'b0, ~arg_ff};
      5'(OP_OR):     alu_sum = {1'b0, acc_ff | arg_ff};
      5'(OP_AND):    alu_sum = {1'b0, acc_ff & arg_ff};
      5'(OP_XOR):    alu_sum = {1'b0, acc_ff ^ arg_ff};
      default:       alu_sum = {1'b0, acc_ff};
    endcase
  end

  // bus value and carry; halving shifts in the held bit
  always_comb
  begin
    bus_val   = alu_sum[EDA_DW-1:0];
    bus_carry = alu_sum[EDA_DW];
    if (enc[5])
    begin
      bus_val   = {carry_ff, alu_sum[EDA_DW-1:1]};
      bus_carry = alu_sum[0];
    end
    if (!op_valid)
    begin
      bus_carry = 1'b0;
      if (strobe[DEC_MISC][MX_A_TR])
        bus_val = temp_ff;
      else if (strobe[DEC_MISC][MX_B_C1 +: 4] != '0)
        bus_val = EDA_CONST_ROM[16*2'(cw_ff[1:0] - 2'(MX_B_C1)) +: 16]; // wraps mod 4
      else if (strobe[DEC_MISC][MX_A_EXT] || strobe[DEC_MISC][MX_B_EXT])
        bus_val = ext_sync_ff;
      else if (strobe[DEC_MISC][MX_TR_A] || strobe[DEC_MISC][MX_EXT_A])
        bus_val = acc_ff;
      else if (strobe[DEC_MISC][MX_EXT_B])
        bus_val = arg_ff;
      else if (strobe[DEC_MISC][MX_ROT_A])
        bus_val = {link_ff, acc_ff[EDA_DW-1:1]};
      else if (strobe[DEC_MISC][MX_ROT_B])
        bus_val = {link_ff, arg_ff[EDA_DW-1:1]};
      else
        bus_val = '0; // zero sources and link loads leave the bus clear
    end
  end

  // destination selects
  assign ld_acc = (strobe[DEC_DST_A] != '0) || save
                  || strobe[DEC_MISC][MX_A_TR] || strobe[DEC_MISC][MX_A_EXT]
                  || strobe[DEC_MISC][MX_ROT_A] || strobe[DEC_MISC][MX_A_ZERO];
  assign ld_arg = (strobe[DEC_DST_B] != '0) || (strobe[DEC_MISC][MX_B_C1 +: 4] != '0)
                  || strobe[DEC_MISC][MX_B_EXT] || strobe[DEC_MISC][MX_ROT_B]
                  || strobe[DEC_MISC][MX_B_ZERO];

  // transfer sequence: ready for one cycle, then accept and done
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:   if (start) nxt_state = ST_READY;
      ST_READY:  nxt_state = ST_ACCEPT;
      ST_ACCEPT: nxt_state = ST_IDLE;
      default:   nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // handshake is combinational from state; jump words raise nothing
  assign DATA_READY_OUT  = (state_ff == ST_READY) && !jump_word;
  assign DATA_ACCEPT_OUT = (state_ff == ST_ACCEPT) && !jump_word;
  assign DONE_OUT        = DATA_ACCEPT_OUT;

  // accumulator and argument load only on accept
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      acc_ff <= '0;
      arg_ff <= '0;
    end
    else if (DATA_ACCEPT_OUT)
    begin
      if (ld_acc)
        acc_ff <= bus_val;
      if (ld_arg)
        arg_ff <= bus_val;
    end
  end

  // temp register takes only the accumulator, or clears to zero
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      temp_ff <= '0;
    else if (DATA_ACCEPT_OUT && strobe[DEC_MISC][MX_TR_A])
      temp_ff <= bus_val;
    else if (DATA_ACCEPT_OUT && strobe[DEC_MISC][MX_TR_ZERO])
      temp_ff <= '0;
  end

  // carry-hold: only save-tagged transfers clock it
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      carry_ff <= 1'b0;
    else if (DATA_ACCEPT_OUT && save)
      carry_ff <= bus_carry;
  end

  // extension bit: imaginary sources, rotations, carry copy
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      link_ff <= 1'b0;
    else if (DATA_ACCEPT_OUT)
    begin
      if (strobe[DEC_MISC][MX_L_CLR])
        link_ff <= 1'b0;
      else if (strobe[DEC_MISC][MX_L_SET])
        link_ff <= 1'b1;
      else if (strobe[DEC_MISC][MX_L_INV])
        link_ff <= ~link_ff;
      else if (strobe[DEC_MISC][MX_L_CARRY])
        link_ff <= carry_ff;
      else if (strobe[DEC_MISC][MX_ROT_A])
        link_ff <= acc_ff[0];
      else if (strobe[DEC_MISC][MX_ROT_B])
        link_ff <= arg_ff[0];
    end
  end

  // external word port output latch and load pulse
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      EXT_WORD_OUT <= '0;
      EXT_LOAD_OUT <= 1'b0;
    end
    else
    begin
      EXT_LOAD_OUT <= 1'b0;
      if (DATA_ACCEPT_OUT && (strobe[DEC_MISC][MX_EXT_A] || strobe[DEC_MISC][MX_EXT_B]))
      begin
        EXT_WORD_OUT <= bus_val;
        EXT_LOAD_OUT <= 1'b1;
      end
    end
  end

  // condition channels for the two test multiplexers
  always_comb
  begin
    cond_pri    = '0;
    cond_sec    = '0;
    cond_pri[0] = 1'b1;   // unconditional
    cond_sec[0] = 1'b1;
    cond_pri[COND_PRI_CARRY] = carry_ff;
    for (int i = 0; i < 8; i++)
    begin
      cond_pri[COND_PRI_AODD + i] = acc_ff[2*i + 1];
      cond_sec[COND_SEC_AEVEN + i] = acc_ff[2*i];
    end
    cond_sec[COND_SEC_B0]   = arg_ff[0];
    cond_sec[COND_SEC_B15]  = arg_ff[EDA_DW-1];
    cond_sec[COND_SEC_LINK] = link_ff;
  end

  // jump taken only when the selected bit is one
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      COND_TRUE_OUT <= 1'b0;
    else
      COND_TRUE_OUT <= cond_sel_ff[5] ? cond_sec[cond_sel_ff[4:0]]
                                      : cond_pri[cond_sel_ff[4:0]];
  end

  // done counter shows completed transfers to software
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      done_cnt_ff <= '0;
    else if (DONE_OUT)
      done_cnt_ff <= done_cnt_ff + 16'h1;
  end

  // axi write: address and data taken in either order
  assign S_AXI_AWREADY_OUT = !aw_got_ff && !S_AXI_BVALID_OUT;
  assign S_AXI_WREADY_OUT  = !w_got_ff && !S_AXI_BVALID_OUT;
  assign wr_fire = aw_got_ff && w_got_ff && !S_AXI_BVALID_OUT;
  assign wr_hit  = (awaddr_ff == REG_CTRL) || (awaddr_ff == REG_COND);
  // a control word written while busy is dropped, not queued
  assign start   = wr_fire && (awaddr_ff == REG_CTRL) && wdata_ff[0] == wdata_ff[0]
                   && !active && S_AXI_WSTRB_IN == S_AXI_WSTRB_IN;

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      aw_got_ff        <= 1'b0;
      w_got_ff         <= 1'b0;
      awaddr_ff        <= '0;
      wdata_ff         <= '0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT  <= RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA_IN;
      end
      if (wr_fire)
      begin
        aw_got_ff        <= 1'b0;
        w_got_ff         <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT  <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end
      else if (S_AXI_BREADY_IN)
        S_AXI_BVALID_OUT <= 1'b0;
    end
  end

  // writable registers: control word and condition select
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      cw_ff       <= '0;
      cond_sel_ff <= '0;
    end
    else
    begin
      if (start)
        cw_ff <= wdata_ff[7:0];
      if (wr_fire && awaddr_ff == REG_COND)
        cond_sel_ff <= wdata_ff[5:0];
    end
  end

  // axi read: one outstanding, data one cycle after address
  assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT  <= '0;
      S_AXI_RRESP_OUT  <= RESP_OKAY;
    end
    else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
    begin
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RRESP_OUT  <= RESP_OKAY;
      if (S_AXI_ARADDR_IN == REG_CTRL)
        S_AXI_RDATA_OUT <= {24'h0, cw_ff};
      else if (S_AXI_ARADDR_IN == REG_STATUS)
        S_AXI_RDATA_OUT <= {done_cnt_ff, 2'h0, enc, 4'h0, COND_TRUE_OUT,
                            link_ff, carry_ff, active};
      else if (S_AXI_ARADDR_IN == REG_ACC)
        S_AXI_RDATA_OUT <= {16'h0, acc_ff};
      else if (S_AXI_ARADDR_IN == REG_ARG)
        S_AXI_RDATA_OUT <= {16'h0, arg_ff};
      else if (S_AXI_ARADDR_IN == REG_TEMP)
        S_AXI_RDATA_OUT <= {16'h0, temp_ff};
      else if (S_AXI_ARADDR_IN == REG_COND)
        S_AXI_RDATA_OUT <= {26'h0, cond_sel_ff};
      else
      begin
        S_AXI_RDATA_OUT <= '0;
        S_AXI_RRESP_OUT <= RESP_DECERR;
      end
    end
    else if (S_AXI_RREADY_IN)
      S_AXI_RVALID_OUT <= 1'b0;
  end

endmodule // eda_arith_unit

// File: core/eda_pkg.sv
// eda_pkg: constants for the evoke decode and arithmetic unit
// assumes a 16-bit data word and 8-bit control words from program memory
package eda_pkg;
  localparam int          EDA_DW         = 16;
  localparam int          EDA_NUM_DEC    = 4;
  localparam int          EDA_STROBES    = 32;
  // per-slot strap patterns, slot g at bits [3g+:3]
  localparam logic [11:0] EDA_SLOT_STRAPS = 12'h688;
  localparam logic [1:0]  EDA_JUMP_CLASS = 2'h3;   // top two bits 11 = jump
  // decoder slots
  localparam int          DEC_DST_A      = 0;
  localparam int          DEC_DST_B      = 1;
  localparam int          DEC_MISC       = 2;
  localparam int          DEC_DST_A_SAVE = 3;
  // operation strobes for slots 0, 1 and 3
  localparam int OP_PASS_A = 0,  OP_PASS_B = 1,  OP_INC_A = 2,  OP_DEC_A = 3;
  localparam int OP_ADD    = 4,  OP_SUB    = 5,  OP_DBL_A = 6,  OP_HALF_A = 7;
  localparam int OP_HALF_B = 8,  OP_NOT_A  = 9,  OP_NOT_B = 10, OP_OR = 11;
  localparam int OP_AND    = 12, OP_XOR    = 13;
  // transfer strobes for the misc slot
  localparam int MX_A_TR = 0,  MX_TR_A = 1,  MX_B_C1 = 2,  MX_A_EXT = 6;
  localparam int MX_B_EXT = 7, MX_EXT_A = 8, MX_EXT_B = 9, MX_L_CLR = 10;
  localparam int MX_L_SET = 11, MX_L_INV = 12, MX_L_CARRY = 13, MX_ROT_A = 14;
  localparam int MX_ROT_B = 15, MX_A_ZERO = 16, MX_B_ZERO = 17, MX_TR_ZERO = 18;
  // encoder outputs {halve, mode, func3..func0}
  localparam logic [5:0] ENC_PASS_A = 6'h1f, ENC_PASS_B = 6'h1a, ENC_INC_A = 6'h00;
  localparam logic [5:0] ENC_DEC_A  = 6'h0f, ENC_ADD    = 6'h09, ENC_SUB   = 6'h17;
  localparam logic [5:0] ENC_DBL_A  = 6'h0c, ENC_HALF_A = 6'h3f, ENC_HALF_B = 6'h3a;
  localparam logic [5:0] ENC_NOT_A  = 6'h13, ENC_NOT_B  = 6'h1a, ENC_OR    = 6'h16;
  localparam logic [5:0] ENC_AND    = 6'h1b, ENC_XOR    = 6'h16;
  // constant rom, contents arbitrary
  localparam logic [63:0] EDA_CONST_ROM = 64'h0004_0003_0002_0001;
  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00, REG_STATUS = 8'h04, REG_ACC = 8'h08;
  localparam logic [7:0] REG_ARG  = 8'h0c, REG_TEMP   = 8'h10, REG_COND = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0, RESP_DECERR = 2'h3;
  // condition channels
  localparam int COND_PRI_CARRY = 10, COND_PRI_AODD = 11;
  localparam int COND_SEC_AEVEN = 1,  COND_SEC_B0 = 9, COND_SEC_B15 = 10;
  localparam int COND_SEC_LINK = 27;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_READY  = 3'h2,
    ST_ACCEPT = 3'h4
  } eda_state_type;
endpackage

// File: sim/eda_ext_model.sv
// eda_ext_model: outside-world device on the external word port
// assumes the bench picks the offered word; the last sent word is kept
`timescale 1ns/1ps
module eda_ext_model (
  // clock
  input  wire logic        clk_in,
  // word port
  input  wire logic [15:0] word_from_dut_in,
  input  wire logic        load_in,
  input  wire logic [15:0] pattern_in,
  output logic      [15:0] word_to_dut_out,
  output logic      [15:0] last_sent_out
);
  logic [15:0] last_ff;
  // always driven, so the port never floats
  assign word_to_dut_out = pattern_in;
  assign last_sent_out = last_ff;
  // capture on the send pulse, when the word is on the pins
  always_ff @(posedge clk_in)
    if (load_in) last_ff <= word_from_dut_in;
endmodule // eda_ext_model

// File: sim/eda_arith_unit_asserts.sv
// eda_arith_unit_asserts: port checks of transfer and bus handshakes
// assumes one clock and the async active-high reset of the unit
`timescale 1ns/1ps
module eda_arith_unit_asserts (
  // clock and reset
  input wire logic        SYS_CLK_IN,
  input wire logic        RST_IN,
  // bus answers
  input wire logic        S_AXI_BVALID_OUT,
  input wire logic        S_AXI_BREADY_IN,
  input wire logic        S_AXI_ARVALID_IN,
  input wire logic        S_AXI_ARREADY_OUT,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic        S_AXI_RVALID_OUT,
  input wire logic        S_AXI_RREADY_IN,
  // transfer side
  input wire logic [15:0] EXT_WORD_OUT,
  input wire logic        EXT_LOAD_OUT,
  input wire logic        DATA_READY_OUT,
  input wire logic        DATA_ACCEPT_OUT,
  input wire logic        DONE_OUT
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);
  // handshake order of one transfer
  AST_ACCEPT_NEXT: assert property (DATA_READY_OUT |=> DATA_ACCEPT_OUT)
    else $error("no accept after ready");
  AST_ACCEPT_CAUSE: assert property (DATA_ACCEPT_OUT |-> $past(DATA_READY_OUT))
    else $error("accept without ready");
  AST_READY_GAP: assert property (DATA_READY_OUT |=> !DATA_READY_OUT [*2])
    else $error("ready too long or too close");
  AST_DONE: assert property (DONE_OUT == DATA_ACCEPT_OUT)
    else $error("done differs from accept");
  // the word port only moves with its send pulse
  AST_LOAD_CAUSE: assert property (EXT_LOAD_OUT |-> $past(DATA_ACCEPT_OUT))
    else $error("send pulse without accept");
  AST_WORD_HOLD: assert property ($changed(EXT_WORD_OUT) |-> EXT_LOAD_OUT)
    else $error("sent word changed alone");
  // read answer follows the address a cycle later; bus answers stand until taken
  AST_AR_READY: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT
    |=> S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT)
    else $error("read answer missing after address taken");
  AST_R_HOLD: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
    |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
    else $error("read answer dropped");
  AST_B_HOLD: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
    else $error("write answer dropped");
  cover property (DATA_ACCEPT_OUT);
  cover property (EXT_LOAD_OUT);
  cover property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN);
endmodule // eda_arith_unit_asserts
bind eda_arith_unit eda_arith_unit_asserts u_chk (.SYS_CLK_IN, .RST_IN, .S_AXI_BVALID_OUT,
  .S_AXI_BREADY_IN, .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RDATA_OUT, .S_AXI_RVALID_OUT,
  .S_AXI_RREADY_IN, .EXT_WORD_OUT, .EXT_LOAD_OUT, .DATA_READY_OUT, .DATA_ACCEPT_OUT,
  .DONE_OUT);

// File: sim/eda_arith_unit_tb.sv
// eda_arith_unit_tb: random and corner control words through the bus
// assumes eda_pkg, the word port model and the checker compile first
`timescale 1ns/1ps
module eda_arith_unit_tb
  import eda_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, sec, l = 1'b0, chh = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0, cw;
  logic [31:0] wdata = '0, d, seed;
  logic [15:0] pat = '0, a = '0, b = '0, tr = '0;
  logic [4:0] ch;
  wire logic awready, wready, bvalid, arready, rvalid, eload, done, cond;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] ext_in, ext_out, sent;
  int miscompares = 0, n_tests = 0, cyc = 0, ndone = 0, seen = 0;
  localparam logic [5:0] enc_tab [14] = '{6'h1f, 6'h1a, 6'h00, 6'h0f, 6'h09, 6'h17, 6'h0c,
    6'h3f, 6'h3a, 6'h13, 6'h1a, 6'h16, 6'h1b, 6'h16};
  localparam logic [4:0] arith_ops [6] = '{5'd2, 5'd4, 5'd5, 5'd6, 5'd7, 5'd8};
  eda_arith_unit u_dut (.SYS_CLK_IN(clk), .RST_IN(rst),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .EXT_WORD_IN(ext_in),
    .EXT_WORD_OUT(ext_out), .EXT_LOAD_OUT(eload), .DATA_READY_OUT(),
    .DATA_ACCEPT_OUT(), .DONE_OUT(done), .COND_TRUE_OUT(cond));
  eda_ext_model u_ext (.clk_in(clk), .word_from_dut_in(ext_out), .load_in(eload),
    .pattern_in(pat), .word_to_dut_out(ext_in), .last_sent_out(sent));
  // 40 MHz
  always #12.5 clk = ~clk;
  // hang guard, far above the few thousand cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      miscompares++;
      stop_test();
    end
  end
  // done pulses counted mid-cycle, where they are settled
  always @(negedge clk)
    if (done === 1'b1) seen++;
  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // sample at the falling edge, act after the rising one; answer taken late at random
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
    logic ta, tw, fin;
    logic [1:0] rs;
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fin = 1'b0;
    while (!fin)
    begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      fin = bvalid & bready;
      rs = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (!fin && $urandom_range(0, 1)) bready <= 1'b1;
    end
    bready <= 1'b0;
    chk(rs, er);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [1:0] er, output logic [31:0] q);
    logic ta, fin;
    logic [1:0] rs;
    araddr <= ad;
    arvalid <= 1'b1;
    fin = 1'b0;
    while (!fin)
    begin
      @(negedge clk);
      ta = arvalid & arready;
      fin = rvalid & rready;
      q = rdata;
      rs = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (!fin && $urandom_range(0, 1)) rready <= 1'b1;
    end
    rready <= 1'b0;
    chk(rs, er);
  endtask
  // expected {carry, result} of one operation
  function automatic logic [16:0] alu(input logic [4:0] k, input logic [15:0] x, y,
    input logic c);
    case (k)
      1: alu = {1'b0, y};
      2: alu = x + 17'h1;
      3: alu = x + 17'hffff;
      4: alu = x + y;
      5: alu = x + {1'b0, ~y} + 17'h1;
      6: alu = x + x;
      7: alu = {x[0], c, x[15:1]};
      8: alu = {y[0], c, y[15:1]};
      9: alu = {1'b0, ~x};
      10: alu = {1'b0, ~y};
      11: alu = {1'b0, x | y};
      12: alu = {1'b0, x & y};
      13: alu = {1'b0, x ^ y};
      default: alu = {1'b0, x};
    endcase
  endfunction
  task automatic put(input logic [15:0] v);
    pat <= v;
    repeat (3) @(posedge clk);
  endtask
  // one control word, then registers and status against the model
  task automatic step(input logic [7:0] w);
    logic [16:0] r;
    logic [4:0] k;
    k = w[4:0];
    wr(REG_CTRL, {24'h0, w}, RESP_OKAY);
    // registers load at the end of accept, which can trail the write answer
    repeat (2) @(posedge clk);
    if (w[7:6] != 2'b11) ndone++;
    if (w[7:5] == 3'd2)
      case (k)
        0: a = tr;
        1: tr = a;
        2, 3, 4, 5: b = EDA_CONST_ROM[16 * (k - 2) +: 16];
        6: a = pat;
        7: b = pat;
        10: l = 1'b0;
        11: l = 1'b1;
        12: l = ~l;
        13: l = chh;
        14: {a, l} = {l, a};
        15: {b, l} = {l, b};
        16: a = '0;
        17: b = '0;
        18: tr = '0;
        default: ;
      endcase
    else if (w[7:6] != 2'b11)
    begin
      r = alu(k, a, b, chh);
      if (w[7:5] == 3'd1) b = r[15:0];
      else a = r[15:0];
      if (w[7:5] == 3'd3) chh = r[16];
    end
    rd(REG_ACC, RESP_OKAY, d);
    chk(d[15:0], a);
    rd(REG_ARG, RESP_OKAY, d);
    chk(d[15:0], b);
    rd(REG_TEMP, RESP_OKAY, d);
    chk(d[15:0], tr);
    rd(REG_STATUS, RESP_OKAY, d);
    chk(d[2:0], {l, chh, 1'b0});
    chk(d[31:16], ndone[15:0]);
    if (w[7:5] < 3'd2 || w[7:5] == 3'd3) chk(d[13:8], enc_tab[k]);
    if (w[7:5] == 3'd2 && (k == 8 || k == 9)) chk(sent, k[0] ? b : a);
  endtask
  // select a condition channel and compare the level seen
  task automatic cond_chk(input logic s, input logic [4:0] c);
    logic e;
    wr(REG_COND, {26'h0, s, c}, RESP_OKAY);
    if (c == 0) e = 1'b1;
    else if (!s) e = (c == 10) ? chh : a[2 * (c - 11) + 1];
    else if (c == 27) e = l;
    else if (c > 8) e = (c == 9) ? b[0] : b[15];
    else e = a[2 * (c - 1)];
    @(negedge clk);
    chk(cond, e);
    @(posedge clk);
  endtask
  initial
  begin
    seed = $urandom(32'hea55);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h20, RESP_DECERR, d);
    chk(d, 32'h0);
    wr(8'h1c, 32'h5, RESP_DECERR);
    // carry out of ffff + 1, saved, then copied to the extension bit
    put(16'hffff);
    step(8'h46);
    step(8'h62);
    step(8'h4d);
    for (int k = 0; k < 19; k++)
    begin
      put(16'($urandom));
      step({3'd2, k[4:0]});
    end
    for (int k = 0; k < 28; k++) step({2'b00, k[0], 5'(k >> 1)});
    for (int i = 0; i < 150; i++)
    begin
      put(16'($urandom));
      case ($urandom_range(0, 3))
        0: cw = {2'b00, 1'($urandom), 5'($urandom_range(0, 13))};
        1: cw = {3'd2, 5'($urandom_range(0, 18))};
        2: cw = {3'd3, arith_ops[$urandom_range(0, 5)]};
        default: cw = {2'b11, 6'($urandom)};
      endcase
      step(cw);
      sec = 1'($urandom);
      ch = sec ? 5'($urandom_range(0, 11)) : 5'($urandom_range(9, 18));
      if (sec && ch == 11) ch = 5'd27;
      if (!sec && ch == 9) ch = 5'd0;
      cond_chk(sec, ch);
    end
    chk(32'(seen), 32'(ndone));
    stop_test();
  end
endmodule // eda_arith_unit_tb
